/* File: afi_consts.svh */
// Purpose: constants of the converter serial frame interface
// Assumes: included by bare name
// Notes:   definitions only
`ifndef AFI_CONSTS_SVH
`define AFI_CONSTS_SVH
`define AFI_FRAME_BITS    144
`define AFI_CMD_BITS      16
`define AFI_STRAP_ASYNC   2'h0
`define AFI_STRAP_MASTER  2'h1
`define AFI_STRAP_SLAVE   2'h3
`define AFI_STROBE_IDLE   1'b1
`define AFI_DOUT_RESET    1'b0
`define AFI_RATE_WIDTH    16
`endif

/* File: afi_pkg.sv */
// Purpose: types of the converter serial frame interface
// Assumes: afi_consts.svh holds the numbers
// Notes:   gray codes along the usual path
`include "afi_consts.svh"
package afi_pkg;
  typedef enum logic [1:0] {
    MODE_ASYNC  = `AFI_STRAP_ASYNC,
    MODE_MASTER = `AFI_STRAP_MASTER,
    MODE_SLAVE  = `AFI_STRAP_SLAVE
  } afi_mode_e;
  typedef enum logic [1:0] {
    FR_IDLE  = 2'h0,
    FR_SHIFT = 2'h1,
    FR_DONE  = 2'h3
  } afi_frame_e;
  typedef struct packed {
    logic                       internal_clock_source_sel;
    logic [2:0]                 clock_config_first_div;
    logic [2:0]                 modulator_clock_divider;
    logic [`AFI_RATE_WIDTH-1:0] data_rate_ticks;
  } afi_cfg_s;
  typedef struct packed {
    logic resync_fault_flag;
    logic data_overrun_flag;
  } afi_flags_s;
endpackage : afi_pkg

/* File: afi_top.sv */
// Purpose: serial frame interface of a multi-channel delta-sigma converter
// Assumes: all inputs synchronous to CLOCK; CLOCK stands for the clock input pin
// Notes:   SPI with clock polarity 0, clock phase 1 only
// Summary of operation
// [R1]: async mode, chip select rising at frame end drives strobe high
// [R2]: master mode drives SCLK, strobe and DOUT; host times DIN to SCLK
// [R3]: master SCLK equals internal clock divided from clock input by first config
// [R4]: master SCLK toggles continuously; frame starts at strobe falling edge
// [R5]: DIN sampled on SCLK falling edge in every mode
// [R6]: received command takes effect only after the frame completes
// [R7]: each DOUT bit shifted out on SCLK rising edge
// [R8]: DOUT tristated while chip select high and after the last bit
// [R9]: master strobe falling coincides with loading new data into shifter
// [R10]: master strobe returns high after last frame bit
// [R11]: host sets internal clock fast enough to finish frame before next data
// [R12]: slave mode takes chip select, SCLK, DIN, strobe as inputs; drives DOUT only
// [R13]: host holds chip select low for the whole transfer
// [R14]: chip select high resets frame, ignores SCLK and DIN, tristates DOUT
// [R15]: slave source select picks clock input or SCLK as internal clock
// [R16]: host keeps SCLK continuous and clean when it is the internal clock
// [R17]: modulator clock divided from internal clock by three-bit divider
// [R18]: slave strobe falling edges checked against internal data update
// [R19]: unexpected strobe edge sets resync fault flag and resets filter
// [R20]: host may raise strobe any time but keeps falling edges on rate
// [R21]: host starts slave frame with chip select falling, with or after strobe
// [R22]: interface mode taken from strap once after reset
// [R23]: clock polarity 0, clock phase 1 only
// [R24]: async overrun pulses strobe high half modulator period, sets overrun flag
// [R25]: frame bit counter clears at frame start and marks the last bit
`timescale 1ns/1ps
`include "afi_consts.svh"
module afi_top #(
  parameter int FRAME_BITS = `AFI_FRAME_BITS,
  parameter int CMD_BITS   = `AFI_CMD_BITS
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic [1:0]            MODE_STRAP,
  input  wire afi_pkg::afi_cfg_s     CONFIG,
  input  wire logic [FRAME_BITS-1:0] CONV_DATA,
  input  wire afi_pkg::afi_flags_s   FLAG_CLEAR,
  input  wire logic                  CS_N,
  input  wire logic                  SCLK_I,
  input  wire logic                  DIN,
  input  wire logic                  DATA_READY_STROBE_N_I,
  output logic                       SCLK_O,
  output logic                       SCLK_OE,
  output logic                       DATA_READY_STROBE_N_O,
  output logic                       DATA_READY_STROBE_N_OE,
  output logic                       DOUT_O,
  output logic                       DOUT_OE,
  output logic [CMD_BITS-1:0]        CMD_WORD,
  output logic                       CMD_VALID,
  output afi_pkg::afi_flags_s        FLAGS,
  output logic                       MOD_TICK,
  output logic                       DATA_UPDATE,
  output logic                       FILTER_RESET,
  output afi_pkg::afi_mode_e         MODE
);
  localparam int CW = $clog2(FRAME_BITS + 1);

  if (FRAME_BITS <= CMD_BITS || CMD_BITS < 2) begin : g_check
    $error("frame must be longer than the command word");
  end

  // mode strap
  afi_pkg::afi_mode_e mode_reg, mode_next;
  logic               taken_reg, taken_next;
  logic               sclk_oe_reg, sclk_oe_next;
  logic               strb_oe_reg, strb_oe_next;

  always_comb begin
    mode_next  = mode_reg;
    taken_next = 1'b1;
    if (!taken_reg) begin
      case (MODE_STRAP)                                          // [R22]
        `AFI_STRAP_MASTER: mode_next = afi_pkg::MODE_MASTER;
        `AFI_STRAP_SLAVE:  mode_next = afi_pkg::MODE_SLAVE;
        default:           mode_next = afi_pkg::MODE_ASYNC;
      endcase
    end
    sclk_oe_next = (mode_next == afi_pkg::MODE_MASTER);         // [R2]
    strb_oe_next = (mode_next != afi_pkg::MODE_SLAVE);          // [R12]
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      mode_reg    <= afi_pkg::MODE_ASYNC;
      taken_reg   <= 1'b0;
      sclk_oe_reg <= 1'b0;
      strb_oe_reg <= 1'b1;
    end else begin
      mode_reg    <= mode_next;
      taken_reg   <= taken_next;
      sclk_oe_reg <= sclk_oe_next;
      strb_oe_reg <= strb_oe_next;
    end
  end

  wire is_master = (mode_reg == afi_pkg::MODE_MASTER);
  wire is_slave  = (mode_reg == afi_pkg::MODE_SLAVE);

  // internal, serial and modulator clocks
  logic [2:0]                 hp_cnt_reg, hp_cnt_next;
  logic                       sclk_o_reg, sclk_o_next;
  logic                       sclk_prev_reg;
  logic                       strb_prev_reg;
  logic [3:0]                 mod_cnt_reg, mod_cnt_next;
  logic [`AFI_RATE_WIDTH-1:0] conv_cnt_reg, conv_cnt_next;
  logic                       mod_tick_reg, mod_tick_next;
  logic                       update_reg, update_next;
  logic                       frst_reg, frst_next;
  logic                       gen_edge, ic_edge, mod_last, rate_wrap;
  logic                       strb_fall_in, fault;

  always_comb begin
    // a counter already past a lowered divider wraps at once instead of running to 7
    gen_edge     = (hp_cnt_reg >= CONFIG.clock_config_first_div);  // [R3]
    hp_cnt_next  = gen_edge ? 3'h0 : hp_cnt_reg + 3'h1;
    sclk_o_next  = gen_edge ? ~sclk_o_reg : sclk_o_reg;           // [R4]
    // SCLK as internal clock: each of its edges is one half period
    ic_edge      = (is_slave && CONFIG.internal_clock_source_sel) ?
                   (SCLK_I ^ sclk_prev_reg) : gen_edge;           // [R15]
    mod_last     = (mod_cnt_reg == {CONFIG.modulator_clock_divider, 1'b1});
    mod_cnt_next = ic_edge ? (mod_last ? 4'h0 : mod_cnt_reg + 4'h1) : mod_cnt_reg;
    mod_tick_next = ic_edge & mod_last;                           // [R17]
    rate_wrap    = ({1'b0, conv_cnt_reg} + 17'h1) >= {1'b0, CONFIG.data_rate_ticks};
    conv_cnt_next = conv_cnt_reg;
    if (mod_tick_next) begin
      conv_cnt_next = rate_wrap ? '0 : conv_cnt_reg + 16'h1;
    end
    // edge valid only within the modulator period after an update
    strb_fall_in = is_slave & strb_prev_reg & ~DATA_READY_STROBE_N_I;
    fault        = strb_fall_in & (conv_cnt_reg != '0);         // [R18]
    if (fault) begin
      conv_cnt_next = '0;                                         // [R19]
      mod_cnt_next  = 4'h0;
    end
    update_next  = mod_tick_next & rate_wrap & ~fault;
    frst_next    = fault;                                         // [R19]
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      hp_cnt_reg    <= 3'h0;
      sclk_o_reg    <= 1'b0;
      sclk_prev_reg <= 1'b0;
      strb_prev_reg <= `AFI_STROBE_IDLE;
      mod_cnt_reg   <= 4'h0;
      conv_cnt_reg  <= '0;
      mod_tick_reg  <= 1'b0;
      update_reg    <= 1'b0;
      frst_reg      <= 1'b0;
    end else begin
      hp_cnt_reg    <= hp_cnt_next;
      sclk_o_reg    <= sclk_o_next;
      sclk_prev_reg <= SCLK_I;
      strb_prev_reg <= DATA_READY_STROBE_N_I;
      mod_cnt_reg   <= mod_cnt_next;
      conv_cnt_reg  <= conv_cnt_next;
      mod_tick_reg  <= mod_tick_next;
      update_reg    <= update_next;
      frst_reg      <= frst_next;
    end
  end

  // frame engine
  afi_pkg::afi_frame_e fr_reg, fr_next;
  logic [CW-1:0]         bit_cnt_reg, bit_cnt_next;
  logic [FRAME_BITS-1:0] tx_reg, tx_next;
  logic [FRAME_BITS-1:0] hold_reg, hold_next;
  logic [CMD_BITS-1:0]   rx_reg, rx_next;
  logic [CMD_BITS-1:0]   cmd_reg, cmd_next;
  logic                  cmd_vld_reg, cmd_vld_next;
  logic                  dout_reg, dout_next;
  logic                  dout_oe_reg, dout_oe_next;
  logic                  strb_reg, strb_next;
  logic                  ovr_reg, ovr_next;
  logic [2:0]            ovr_cnt_reg, ovr_cnt_next;
  afi_pkg::afi_flags_s   flags_reg, flags_next;
  logic                  cs_prev_reg;
  logic                  rise, fall, busy, last, set_ovr, frame_end;

  always_comb begin
    fr_next      = fr_reg;
    bit_cnt_next = bit_cnt_reg;
    tx_next      = tx_reg;
    hold_next    = hold_reg;
    rx_next      = rx_reg;
    cmd_next     = cmd_reg;
    cmd_vld_next = 1'b0;
    dout_next    = dout_reg;
    dout_oe_next = dout_oe_reg;
    strb_next    = strb_reg;
    ovr_next     = ovr_reg;
    ovr_cnt_next = ovr_cnt_reg;
    set_ovr      = 1'b0;
    frame_end    = 1'b0;
    busy         = (fr_reg == afi_pkg::FR_SHIFT);
    // master shifts on its own SCLK; the chip select input is not used there
    if (is_master) begin
      rise = gen_edge & ~sclk_o_reg;                               // [R23]
      fall = gen_edge & sclk_o_reg;
    end else begin
      rise = ~CS_N & SCLK_I & ~sclk_prev_reg;                      // [R14]
      fall = ~CS_N & ~SCLK_I & sclk_prev_reg;
    end
    last = (bit_cnt_reg == CW'(FRAME_BITS - 1));                  // [R25]

    if (update_reg) begin
      if (busy) begin
        set_ovr = 1'b1;                                           // [R24]
      end else if (is_master) begin
        tx_next      = CONV_DATA;                                 // [R9]
        strb_next    = 1'b0;                                      // [R4]
        fr_next      = afi_pkg::FR_SHIFT;
        bit_cnt_next = '0;                                        // [R25]
      end else begin
        hold_next = CONV_DATA;
        strb_next = 1'b0;
      end
    end
    if (set_ovr && !is_master) begin
      strb_next    = 1'b1;                                        // [R24]
      ovr_next     = 1'b1;
      ovr_cnt_next = 3'h0;
    end else if (ovr_reg && ic_edge) begin
      ovr_cnt_next = ovr_cnt_reg + 3'h1;
      if (ovr_cnt_reg == CONFIG.modulator_clock_divider) begin
        ovr_next  = 1'b0;
        strb_next = 1'b0;
      end
    end

    if (busy && rise) begin
      dout_next    = tx_reg[FRAME_BITS-1];                        // [R7]
      dout_oe_next = 1'b1;
      tx_next      = {tx_reg[FRAME_BITS-2:0], 1'b0};
    end
    if (busy && fall) begin
      if (bit_cnt_reg < CW'(CMD_BITS)) begin
        rx_next = {rx_reg[CMD_BITS-2:0], DIN};                    // [R5]
      end
      bit_cnt_next = bit_cnt_reg + CW'(1);
      if (last) begin
        dout_oe_next = 1'b0;                                      // [R8]
        fr_next      = afi_pkg::FR_DONE;
        if (is_master) begin
          strb_next = 1'b1;                                       // [R10]
        end
      end
    end

    if (is_master) begin
      if (fr_reg == afi_pkg::FR_DONE) begin
        frame_end = 1'b1;
        fr_next   = afi_pkg::FR_IDLE;
      end
    end else if (CS_N) begin
      frame_end    = ~cs_prev_reg & (bit_cnt_reg >= CW'(CMD_BITS));
      fr_next      = afi_pkg::FR_IDLE;                            // [R14]
      bit_cnt_next = '0;
      dout_oe_next = 1'b0;                                        // [R8]
      // new data landing with the chip select rise keeps its strobe fall
      if (!cs_prev_reg && mode_reg == afi_pkg::MODE_ASYNC && !ovr_next &&
          !(update_reg && !busy)) begin
        strb_next = 1'b1;                                         // [R1]
      end
    end else if (cs_prev_reg) begin
      fr_next      = afi_pkg::FR_SHIFT;                           // [R21]
      bit_cnt_next = '0;                                          // [R25]
      tx_next      = (update_reg && !busy) ? CONV_DATA : hold_reg;
    end
    if (frame_end) begin
      cmd_next     = rx_reg;                                      // [R6]
      cmd_vld_next = 1'b1;
    end

    // a set in the same cycle as a clear wins
    flags_next.resync_fault_flag = fault |
      (flags_reg.resync_fault_flag & ~FLAG_CLEAR.resync_fault_flag);
    flags_next.data_overrun_flag = set_ovr |
      (flags_reg.data_overrun_flag & ~FLAG_CLEAR.data_overrun_flag);
  end

  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      fr_reg      <= afi_pkg::FR_IDLE;
      bit_cnt_reg <= '0;
      tx_reg      <= '0;
      hold_reg    <= '0;
      rx_reg      <= '0;
      cmd_reg     <= '0;
      cmd_vld_reg <= 1'b0;
      dout_reg    <= `AFI_DOUT_RESET;
      dout_oe_reg <= 1'b0;
      strb_reg    <= `AFI_STROBE_IDLE;
      ovr_reg     <= 1'b0;
      ovr_cnt_reg <= 3'h0;
      flags_reg   <= '0;
      cs_prev_reg <= 1'b1;
    end else begin
      fr_reg      <= fr_next;
      bit_cnt_reg <= bit_cnt_next;
      tx_reg      <= tx_next;
      hold_reg    <= hold_next;
      rx_reg      <= rx_next;
      cmd_reg     <= cmd_next;
      cmd_vld_reg <= cmd_vld_next;
      dout_reg    <= dout_next;
      dout_oe_reg <= dout_oe_next;
      strb_reg    <= strb_next;
      ovr_reg     <= ovr_next;
      ovr_cnt_reg <= ovr_cnt_next;
      flags_reg   <= flags_next;
      cs_prev_reg <= CS_N;
    end
  end

  assign SCLK_O                 = sclk_o_reg;
  assign SCLK_OE                = sclk_oe_reg;
  assign DATA_READY_STROBE_N_O  = strb_reg;
  assign DATA_READY_STROBE_N_OE = strb_oe_reg;
  assign DOUT_O                 = dout_reg;
  assign DOUT_OE                = dout_oe_reg;
  assign CMD_WORD               = cmd_reg;
  assign CMD_VALID              = cmd_vld_reg;
  assign FLAGS                  = flags_reg;
  assign MOD_TICK               = mod_tick_reg;
  assign DATA_UPDATE            = update_reg;
  assign FILTER_RESET           = frst_reg;
  assign MODE                   = mode_reg;
endmodule : afi_top

/* File: afi_monitor.sv */
// Purpose: port checker of the converter frame interface
// Assumes: mode changes only through reset
// Notes:   bound to afi_top
`timescale 1ns/1ps
`include "afi_consts.svh"
module afi_monitor #(
  parameter int FRAME_BITS = `AFI_FRAME_BITS,
  parameter int CMD_BITS   = `AFI_CMD_BITS
) (
  input wire logic                CLOCK,
  input wire logic                RESET_N,
  input wire logic                CS_N,
  input wire afi_pkg::afi_cfg_s   CONFIG,
  input wire logic                SCLK_O,
  input wire logic                SCLK_OE,
  input wire logic                DATA_READY_STROBE_N_O,
  input wire logic                DATA_READY_STROBE_N_OE,
  input wire logic                DOUT_OE,
  input wire logic                MOD_TICK,
  input wire logic                DATA_UPDATE,
  input wire logic                FILTER_RESET,
  input wire afi_pkg::afi_flags_s FLAGS,
  input wire afi_pkg::afi_mode_e  MODE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_cs_rise;
    $rose(CS_N) ##0 (MODE != afi_pkg::MODE_MASTER);
  endsequence
  property p_sclk_oe;
    SCLK_OE == (MODE == afi_pkg::MODE_MASTER);
  endproperty
  property p_strobe_oe;
    DATA_READY_STROBE_N_OE == (MODE != afi_pkg::MODE_SLAVE);
  endproperty
  property p_cs_dout;
    s_cs_rise |=> !DOUT_OE;
  endproperty
  property p_cs_strobe;
    s_cs_rise ##0 (MODE == afi_pkg::MODE_ASYNC && !DATA_UPDATE && !DATA_READY_STROBE_N_O)
      |=> DATA_READY_STROBE_N_O;
  endproperty
  // two cycles of history so the first master cycles after reset are skipped
  property p_sclk_run;
    (MODE == afi_pkg::MODE_MASTER && $past(MODE, 2) == afi_pkg::MODE_MASTER
      && CONFIG.clock_config_first_div == 3'h0
      && $past(CONFIG.clock_config_first_div, 2) == 3'h0) |-> SCLK_O != $past(SCLK_O);
  endproperty
  property p_strobe_load;
    $fell(DATA_READY_STROBE_N_O) && MODE == afi_pkg::MODE_MASTER |-> $past(DATA_UPDATE);
  endproperty
  property p_frame_close;
    $rose(DATA_READY_STROBE_N_O) && MODE == afi_pkg::MODE_MASTER |-> !DOUT_OE;
  endproperty
  property p_update_tick;
    DATA_UPDATE |-> MOD_TICK;
  endproperty
  property p_resync;
    FILTER_RESET |-> FLAGS.resync_fault_flag && MODE == afi_pkg::MODE_SLAVE;
  endproperty
  a_sclk_oe: assert property (p_sclk_oe) else $error("sclk enable wrong");
  a_strobe_oe: assert property (p_strobe_oe) else $error("strobe enable wrong");
  a_cs_dout: assert property (p_cs_dout) else $error("dout on after cs");
  a_cs_strobe: assert property (p_cs_strobe) else $error("strobe low after cs");
  a_sclk_run: assert property (p_sclk_run) else $error("sclk stalled");
  a_strobe_load: assert property (p_strobe_load) else $error("strobe fell alone");
  a_frame_close: assert property (p_frame_close) else $error("dout on at close");
  a_update_tick: assert property (p_update_tick) else $error("update off tick");
  a_resync: assert property (p_resync) else $error("filter reset unflagged");
endmodule : afi_monitor
bind afi_top afi_monitor #(.FRAME_BITS(FRAME_BITS), .CMD_BITS(CMD_BITS)) u_mon (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .CS_N(CS_N), .CONFIG(CONFIG), .SCLK_O(SCLK_O),
  .SCLK_OE(SCLK_OE), .DATA_READY_STROBE_N_O(DATA_READY_STROBE_N_O),
  .DATA_READY_STROBE_N_OE(DATA_READY_STROBE_N_OE), .DOUT_OE(DOUT_OE), .MOD_TICK(MOD_TICK),
  .DATA_UPDATE(DATA_UPDATE), .FILTER_RESET(FILTER_RESET), .FLAGS(FLAGS), .MODE(MODE));

/* File: afi_host_model.sv */
// Purpose: host side of the serial frame link
// Assumes: tasks entered 5 ns after a clock edge
// Notes:   serial clock idles low, stands still outside frames except while run_clk toggles it
`timescale 1ns/1ps
module afi_host_model (
  input  wire logic clk,
  input  wire logic dout,
  input  wire logic sclk_dev,
  input  wire logic dout_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  output logic      strobe_n
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    strobe_n = 1'b1;
  end
  task hw(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : hw
  task cs_set(input logic v);
    cs_n = v; // low for the whole frame, after the strobe fall
  endtask : cs_set
  task set_strobe(input logic v);
    strobe_n = v; // rise any time, falls only where the bench places them
  endtask : set_strobe
  task run_clk(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = ~sclk; // free-running, no pauses
      hw(2);
    end
  endtask : run_clk
  // each level held two cycles so the device sees every edge
  task frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      din = tx[n-1-i]; // data moves on the rising edge
      hw(2);
      rx = {rx[30:0], dout};
      sclk = 1'b0;
      hw(2);
    end
  endtask : frame
  task mframe(input int n, input logic [31:0] tx, output logic [31:0] rx, output int got);
    logic prev;
    rx = '0;
    got = 0;
    prev = 1'b0;
    for (int t = 0; t < 2000 && got < n; t++) begin
      if (sclk_dev && !prev && dout_oe) begin
        rx = {rx[30:0], dout};
        din = tx[n-1-got]; // timed to the device clock rise
        got++;
      end
      prev = sclk_dev;
      hw(1);
    end
  endtask : mframe
endmodule : afi_host_model

/* File: tb_top.sv */
// Purpose: self-checking bench of the converter frame interface
// Assumes: short frame of 24 bits, 8 command bits
// Notes:   rate ticks chosen so frames end before new data
`timescale 1ns/1ps
module tb_top;
  localparam int FB = 24;
  localparam int CB = 8;
  logic                clock = 1'b0;
  logic                reset_n, cs_n, sclk, din, strobe_n, last_d;
  logic                sclk_o, sclk_oe, str_o, str_oe, dout_o, dout_oe, dout_w;
  logic                cmd_v, mtick, dupd, frst;
  logic [1:0]          strap;
  logic [FB-1:0]       conv;
  logic [CB-1:0]       cmd;
  logic [31:0]         rx;
  afi_pkg::afi_cfg_s   cfg;
  afi_pkg::afi_flags_s fclr, flags;
  afi_pkg::afi_mode_e  mode;
  int                  n_mismatch, n_tests, k, got;
  int                  rows [4][5] = '{'{0,0,0,2,2}, '{1,0,3,4,12}, '{0,7,2,16,32},
                                       '{7,1,1,32,32}};
  always #25 clock = ~clock;
  // released line shows the inverse, never a held value
  always @(posedge clock) if (dout_oe) last_d <= dout_o;
  assign dout_w = dout_oe ? dout_o : ~last_d;
  afi_top #(.FRAME_BITS(FB), .CMD_BITS(CB)) u_dut (
    .CLOCK(clock), .RESET_N(reset_n), .MODE_STRAP(strap), .CONFIG(cfg), .CONV_DATA(conv),
    .FLAG_CLEAR(fclr), .CS_N(cs_n), .SCLK_I(sclk), .DIN(din), .DATA_READY_STROBE_N_I(strobe_n),
    .SCLK_O(sclk_o), .SCLK_OE(sclk_oe), .DATA_READY_STROBE_N_O(str_o),
    .DATA_READY_STROBE_N_OE(str_oe), .DOUT_O(dout_o), .DOUT_OE(dout_oe), .CMD_WORD(cmd),
    .CMD_VALID(cmd_v), .FLAGS(flags), .MOD_TICK(mtick), .DATA_UPDATE(dupd),
    .FILTER_RESET(frst), .MODE(mode));
  afi_host_model u_host (.clk(clock), .dout(dout_w), .sclk_dev(sclk_o), .dout_oe(dout_oe),
    .cs_n(cs_n), .sclk(sclk), .din(din), .strobe_n(strobe_n));
  task stop_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  task chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task cyc(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask : cyc
  task wait_for(input int w, input logic v, output int n);
    logic s;
    for (n = 0; n < 1000; n++) begin
      s = (w == 0) ? str_o : (w == 1) ? dupd : (w == 2) ? mtick : sclk_o;
      if (s === v) break;
      cyc(1);
    end
    if (n == 1000) begin
      n_mismatch++;
      stop_test;
    end
  endtask : wait_for
  task gap(input int w, output int n);
    repeat (3) begin
      cyc(1);
      wait_for(w, 1'b1, n);
    end
    n = n + 1;
  endtask : gap
  task do_reset(input logic [1:0] s, input logic [2:0] dv, input logic [15:0] rt);
    reset_n = 1'b0;
    strap = s;
    cfg = '{1'b0, dv, 3'h0, rt};
    cyc(4);
    chk_bit("rst strobe", 1'b1, str_o);
    chk_bit("rst dout_oe", 1'b0, dout_oe);
    chk_word("rst mode", 32'(afi_pkg::MODE_ASYNC), 32'(mode));
    chk_word("rst flags", 32'h0, 32'(flags));
    reset_n = 1'b1;
    cyc(3);
    chk_word("mode", 32'(s == 2'h3 ? afi_pkg::MODE_SLAVE : s == 2'h1 ? afi_pkg::MODE_MASTER
      : afi_pkg::MODE_ASYNC), 32'(mode));
  endtask : do_reset
  initial begin
    conv = 24'ha5c3e1;
    fclr = '0;
    do_reset(2'h0, 3'h0, 16'h0050);
    for (int r = 0; r < 4; r++) begin
      cfg = '{1'b0, 3'(rows[r][0]), 3'(rows[r][1]), 16'(rows[r][2])};
      gap(2, k);
      chk_word("mod gap", 32'(rows[r][3]), 32'(k));
      gap(1, k);
      chk_word("update gap", 32'(rows[r][4]), 32'(k));
    end
    do_reset(2'h0, 3'h0, 16'h0050); // rate leaves room for a full frame
    wait_for(0, 1'b0, k);
    u_host.cs_set(1'b0);
    cyc(2);
    u_host.frame(FB, 32'h5a0000, rx);
    chk_word("async data", 32'(conv), rx);
    chk_bit("dout_oe after lsb", 1'b0, dout_oe);
    chk_word("cmd held", 32'h0, 32'(cmd));
    u_host.cs_set(1'b1);
    cyc(1);
    chk_bit("strobe at cs", 1'b1, str_o);
    chk_bit("cmd valid", 1'b1, cmd_v);
    chk_word("cmd", 32'h5a, 32'(cmd));
    wait_for(0, 1'b0, k);
    u_host.cs_set(1'b0);
    wait_for(1, 1'b1, k);
    cyc(1);
    chk_bit("overrun pulse", 1'b1, str_o);
    cyc(1);
    chk_bit("overrun end", 1'b0, str_o);
    chk_bit("overrun flag", 1'b1, flags.data_overrun_flag);
    u_host.cs_set(1'b1);
    fclr = '{1'b0, 1'b1};
    cyc(1);
    fclr = '0;
    cyc(1);
    chk_bit("overrun clear", 1'b0, flags.data_overrun_flag);
    conv = 24'h3c5a96;
    do_reset(2'h1, 3'h1, 16'h0050);
    chk_bit("master sclk oe", 1'b1, sclk_oe);
    wait_for(3, 1'b0, k);
    wait_for(3, 1'b1, k);
    wait_for(3, 1'b0, k);
    chk_word("sclk half", 32'h2, 32'(k));
    wait_for(0, 1'b0, k);
    u_host.mframe(FB, 32'hc30000, rx, got);
    chk_word("master bits", 32'(FB), 32'(got));
    chk_word("master data", 32'(conv), rx);
    wait_for(0, 1'b1, k);
    chk_bit("master close", 1'b0, dout_oe);
    cyc(2);
    chk_word("master cmd", 32'hc3, 32'(cmd));
    cfg.clock_config_first_div = 3'h0;
    cyc(6);
    do_reset(2'h3, 3'h0, 16'h0050);
    chk_bit("slave sclk oe", 1'b0, sclk_oe);
    chk_bit("slave strobe oe", 1'b0, str_oe);
    wait_for(1, 1'b1, k);
    u_host.set_strobe(1'b0);
    cyc(1);
    chk_bit("sync edge", 1'b0, frst);
    cyc(1);
    u_host.cs_set(1'b0);
    cyc(2);
    u_host.frame(FB, 32'h690000, rx);
    chk_word("slave data", 32'(conv), rx);
    u_host.cs_set(1'b1);
    u_host.set_strobe(1'b1);
    cyc(2);
    chk_word("slave cmd", 32'h69, 32'(cmd));
    chk_bit("no resync", 1'b0, flags.resync_fault_flag);
    wait_for(1, 1'b1, k);
    cyc(20);
    u_host.set_strobe(1'b0);
    cyc(1);
    chk_bit("filter reset", 1'b1, frst);
    chk_bit("resync flag", 1'b1, flags.resync_fault_flag);
    u_host.set_strobe(1'b1);
    fclr = '{1'b1, 1'b0};
    cyc(1);
    fclr = '0;
    cyc(1);
    chk_bit("resync clear", 1'b0, flags.resync_fault_flag);
    cfg.internal_clock_source_sel = 1'b1;
    fork
      u_host.run_clk(80);
      gap(2, k);
    join
    chk_word("sclk mod gap", 32'h4, 32'(k));
    do_reset(2'h2, 3'h0, 16'h0050);
    strap = 2'h1;
    cyc(2);
    chk_word("strap once", 32'(afi_pkg::MODE_ASYNC), 32'(mode));
    stop_test;
  end
endmodule : tb_top
